// ===== shutter_pkg.sv
package shutter_pkg;

  // ------------------------------------------------------------
  // Widths and counts
  // ------------------------------------------------------------
  localparam int FIELD_W = 12;
  localparam int LINE_W = 12;
  localparam int PIXEL_W = 13;
  localparam int SEL_W = 3;
  localparam int NUM_PULSES = 4;
  localparam int NUM_BIAS = 2;
  localparam int NUM_PINS = 3;

  // ------------------------------------------------------------
  // Trigger bit positions
  // ------------------------------------------------------------
  localparam int TRIG_PULSE0 = 0;
  localparam int TRIG_BIAS_A = 4;
  localparam int TRIG_EXPOSURE = 6;
  localparam int TRIG_READOUT = 7;

  // ------------------------------------------------------------
  // Pin source selector codes
  // ------------------------------------------------------------
  localparam logic [SEL_W-1:0] SEL_PULSE0 = 3'h0;
  localparam logic [SEL_W-1:0] SEL_PULSE3 = 3'h3;
  localparam logic [SEL_W-1:0] SEL_BIAS_A_COMB = 3'h4;
  localparam logic [SEL_W-1:0] SEL_BIAS_B_COMB = 3'h5;
  localparam logic [SEL_W-1:0] SEL_INVALID = 3'h6;
  localparam logic [SEL_W-1:0] SEL_PULSE12_COMB = 3'h7;

  // ------------------------------------------------------------
  // Levels and positions
  // ------------------------------------------------------------
  localparam logic PIN_IDLE_LEVEL = 1'b0;
  localparam logic [FIELD_W-1:0] EXPOSURE_FIELD_FIRST = 12'h000;
  localparam logic [PIXEL_W-1:0] BIAS_ON_PIXEL = 13'h0000;
  localparam logic RESET_STATE_OFF = 1'b0;

  typedef enum logic [1:0] {
    PULSE_IDLE = 2'b00,
    PULSE_SINGLE_WAIT = 2'b01,
    PULSE_SINGLE_RUN = 2'b10,
    PULSE_AUTO = 2'b11
  } pulse_mode_t;

  typedef enum logic [1:0] {
    BIAS_OFF = 2'b00,
    BIAS_ARMED = 2'b01,
    BIAS_ON = 2'b10,
    BIAS_HELD = 2'b11
  } bias_state_t;

endpackage

// ===== gate_pulse_unit.sv
`timescale 1ns/1ps
module gate_pulse_unit
  import shutter_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic vdEdge,
  input wire logic [LINE_W-1:0] lineCount,
  input wire logic [PIXEL_W-1:0] pixelCount,
  input wire logic [FIELD_W-1:0] exposureCount,
  input wire logic exposureActive,
  input wire logic trigWrite,
  input wire logic trigPulse,
  input wire logic trigExposure,
  input wire logic manualEnable,
  input wire logic manualOnState,
  input wire logic [FIELD_W-1:0] pulseOnField,
  input wire logic [LINE_W-1:0] pulseOnLine,
  input wire logic [PIXEL_W-1:0] pulseOnPixel,
  input wire logic [FIELD_W-1:0] pulseOffField,
  input wire logic [LINE_W-1:0] pulseOffLine,
  input wire logic [PIXEL_W-1:0] pulseOffPixel,
  output logic pulseActive,
  output pulse_mode_t pulseMode
);

  // ------------------------------------------------------------
  // Position match
  // ------------------------------------------------------------
  logic pulseOn_ff;
  pulse_mode_t mode_ff;
  pulse_mode_t nxt_mode;
  logic toggled_ff;
  wire onPos = (lineCount == pulseOnLine) && (pixelCount == pulseOnPixel);
  wire offPos = (lineCount == pulseOffLine) && (pixelCount == pulseOffPixel);
  wire autoOnField = exposureActive && (exposureCount == pulseOnField);
  wire autoOffField = exposureActive && (exposureCount == pulseOffField);
  // Field values ignored in single trigger and manual
  wire trigOnHit = ((mode_ff == PULSE_SINGLE_RUN) ||
    ((mode_ff == PULSE_AUTO) && autoOnField)) && onPos;
  wire trigOffHit = ((mode_ff == PULSE_SINGLE_RUN) ||
    ((mode_ff == PULSE_AUTO) && autoOffField)) && offPos;
  // One manual toggle per vertical-sync interval
  wire manOnHit = manualEnable && manualOnState && onPos &&
    !toggled_ff;
  wire manOffHit = manualEnable && !manualOnState && offPos && !toggled_ff;
  wire onHit = manualEnable ? manOnHit : trigOnHit;
  wire offHit = manualEnable ? manOffHit : trigOffHit;

  // ------------------------------------------------------------
  // Operating method
  // ------------------------------------------------------------
  always_comb begin
    nxt_mode = mode_ff;
    unique case (mode_ff)
      PULSE_IDLE: nxt_mode = PULSE_IDLE;
      PULSE_SINGLE_WAIT: if (vdEdge) nxt_mode = PULSE_SINGLE_RUN;
      PULSE_SINGLE_RUN: if (vdEdge) nxt_mode = PULSE_IDLE;
      PULSE_AUTO: if (!exposureActive) nxt_mode = PULSE_IDLE;
    endcase
    if (trigWrite && trigPulse) begin
      // Exposure trigger forces automatic mode
      nxt_mode = trigExposure ? PULSE_AUTO : PULSE_SINGLE_WAIT;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_ff <= PULSE_IDLE;
      pulseOn_ff <= RESET_STATE_OFF;
      toggled_ff <= 1'b0;
    end else begin
      mode_ff <= nxt_mode;
      // Left-on pulse keeps its state; repeated on is harmless
      if (offHit) pulseOn_ff <= 1'b0;
      else if (onHit) pulseOn_ff <= 1'b1;
      // Toggle in the sync cycle uses up the new interval
      if (manOnHit || manOffHit) toggled_ff <= 1'b1;
      else if (vdEdge) toggled_ff <= 1'b0;
    end
  end

  assign pulseActive = pulseOn_ff;
  assign pulseMode = mode_ff;

endmodule // gate_pulse_unit

// ===== ccd_shutter_bias_control.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Mode 0 bias turns on during exposure field holding last drain pulse.
// - Mode 0 turn-on line is programmable to any line of that field.
// - Active bias stays on until readout ends, then turns off.
// - Mode 1 bias stays off until readout starts, then turns on.
// - Hold bit keeps bias on after readout until software clears it.
// - Two bias signals, each routable to any of the three pins.
// - Polarity bit sets bias active level high or low.
// - Gate pulses run in automatic, single-trigger or manual method.
// - Automatic pulse edges use separate field, line and pixel positions.
// - Field values compare against exposure counter, field 0 earliest.
// - On and off use separate field values.
// - Single trigger places both edges in next field, fields ignored.
// - Pulse triggered with exposure runs in automatic mode.
// - Manual state bit picks on or off position; one toggle per interval.
// - Manual control ignores the field values.
// - Per-pulse manual enable works regardless of exposure state.
// - Pulse left on stays on; later trigger only applies turn-off.
// - Bias pin selector: 0-3 pulses, 4/5 bias combiners, 7 pulse12.
// - Mechanical-shutter pin selector uses the same eight-value encoding.
// - Flash pin selector: 0-3 pulses, 4 bias-a, 5 bias-b combiner.
// - Flash selector 6 invalid, 7 selects pulse12 combiner.
// - Bias combiner gives bias, or pulse 0 XOR bias when selected.
// - Pulse12 combiner gives pulse0^pulse1, or pulse0^pulse2 when set.
module ccd_shutter_bias_control
  import shutter_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic vdEdge,
  input wire logic [LINE_W-1:0] lineCount,
  input wire logic [PIXEL_W-1:0] pixelCount,
  input wire logic [FIELD_W-1:0] exposureCount,
  input wire logic exposureActive,
  input wire logic readoutStart,
  input wire logic readoutEnd,
  input wire logic trigWrite,
  input wire logic [7:0] trigBits,
  input wire logic [NUM_BIAS-1:0] biasMode,
  input wire logic [NUM_BIAS-1:0] biasHoldAfterReadout,
  input wire logic [NUM_BIAS-1:0] biasPolarity,
  input wire logic [LINE_W-1:0] biasAOnLine,
  input wire logic [LINE_W-1:0] biasBOnLine,
  input wire logic [NUM_PULSES-1:0] pulsePolarity,
  input wire logic [NUM_PULSES-1:0] pulseManualEnable,
  input wire logic [NUM_PULSES-1:0] pulseManualOn,
  input wire logic [NUM_PULSES*FIELD_W-1:0] pulseOnField,
  input wire logic [NUM_PULSES*LINE_W-1:0] pulseOnLine,
  input wire logic [NUM_PULSES*PIXEL_W-1:0] pulseOnPixel,
  input wire logic [NUM_PULSES*FIELD_W-1:0] pulseOffField,
  input wire logic [NUM_PULSES*LINE_W-1:0] pulseOffLine,
  input wire logic [NUM_PULSES*PIXEL_W-1:0] pulseOffPixel,
  input wire logic biasACombinerSel,
  input wire logic biasBCombinerSel,
  input wire logic pulse12CombinerSel,
  input wire logic [SEL_W-1:0] biasPinSourceSelect,
  input wire logic [SEL_W-1:0] mechShutterPinSourceSelect,
  input wire logic [SEL_W-1:0] flashPinSourceSelect,
  output logic substrateBias,
  output logic mechShutterPin,
  output logic flashPin,
  output logic [NUM_PULSES-1:0] gatePulseState,
  output logic [NUM_BIAS-1:0] biasState
);

  // ------------------------------------------------------------
  // Gate pulses
  // ------------------------------------------------------------
  logic [NUM_PULSES-1:0] pulseActive;
  pulse_mode_t pulseMode [NUM_PULSES];
  wire [NUM_PULSES-1:0] pulseLevel = pulseActive ^ ~pulsePolarity;

  genvar g;
  generate
    for (g = 0; g < NUM_PULSES; g++) begin : gen_pulse
      gate_pulse_unit u_pulse (
        .clk(clk),
        .rst_n(rst_n),
        .vdEdge(vdEdge),
        .lineCount(lineCount),
        .pixelCount(pixelCount),
        .exposureCount(exposureCount),
        .exposureActive(exposureActive),
        .trigWrite(trigWrite),
        .trigPulse(trigBits[TRIG_PULSE0+g]),
        .trigExposure(trigBits[TRIG_EXPOSURE]),
        .manualEnable(pulseManualEnable[g]),
        .manualOnState(pulseManualOn[g]),
        .pulseOnField(pulseOnField[g*FIELD_W +: FIELD_W]),
        .pulseOnLine(pulseOnLine[g*LINE_W +: LINE_W]),
        .pulseOnPixel(pulseOnPixel[g*PIXEL_W +: PIXEL_W]),
        .pulseOffField(pulseOffField[g*FIELD_W +: FIELD_W]),
        .pulseOffLine(pulseOffLine[g*LINE_W +: LINE_W]),
        .pulseOffPixel(pulseOffPixel[g*PIXEL_W +: PIXEL_W]),
        .pulseActive(pulseActive[g]),
        .pulseMode(pulseMode[g])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // Substrate bias sources
  // ------------------------------------------------------------
  bias_state_t biasState_ff [NUM_BIAS];
  bias_state_t nxt_bias [NUM_BIAS];
  wire [LINE_W-1:0] biasOnLine [NUM_BIAS];
  wire [NUM_BIAS-1:0] biasActive;
  wire [NUM_BIAS-1:0] biasLevel;
  wire [NUM_BIAS-1:0] biasOnHit;
  wire exposureField0 = exposureActive &&
    (exposureCount == EXPOSURE_FIELD_FIRST);
  assign biasOnLine[0] = biasAOnLine;
  assign biasOnLine[1] = biasBOnLine;

  generate
    for (g = 0; g < NUM_BIAS; g++) begin : gen_bias
      // Mode 0 turn-on at the start of the programmed line
      assign biasOnHit[g] = biasMode[g] ? readoutStart :
        (exposureField0 && (lineCount == biasOnLine[g]) &&
        (pixelCount == BIAS_ON_PIXEL));
      assign biasActive[g] = (biasState_ff[g] == BIAS_ON) ||
        (biasState_ff[g] == BIAS_HELD);
      assign biasLevel[g] = biasActive[g] ^ ~biasPolarity[g];

      always_comb begin
        nxt_bias[g] = biasState_ff[g];
        unique case (biasState_ff[g])
          BIAS_OFF: nxt_bias[g] = BIAS_OFF;
          BIAS_ARMED: if (biasOnHit[g]) nxt_bias[g] = BIAS_ON;
          BIAS_ON: if (readoutEnd) begin
            nxt_bias[g] = biasHoldAfterReadout[g] ? BIAS_HELD :
              BIAS_OFF;
          end
          BIAS_HELD: begin
            if (!biasHoldAfterReadout[g]) nxt_bias[g] = BIAS_OFF;
          end
        endcase
        if (trigWrite && trigBits[TRIG_BIAS_A+g] &&
            (biasState_ff[g] == BIAS_OFF)) begin
          nxt_bias[g] = BIAS_ARMED;
        end
      end

      always_ff @(posedge clk) begin
        if (!rst_n) biasState_ff[g] <= BIAS_OFF;
        else biasState_ff[g] <= nxt_bias[g];
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // Combiners and pin routing
  // ------------------------------------------------------------
  wire biasAComb = biasACombinerSel ? (pulseLevel[0] ^ biasLevel[0]) :
    biasLevel[0];
  wire biasBComb = biasBCombinerSel ? (pulseLevel[0] ^ biasLevel[1]) :
    biasLevel[1];
  wire pulse12Comb = pulse12CombinerSel ? (pulseLevel[0] ^ pulseLevel[2]) :
    (pulseLevel[0] ^ pulseLevel[1]);
  // Source table indexed by selector code; code 6 is the idle level
  wire [7:0] pinSource = {pulse12Comb, PIN_IDLE_LEVEL, biasBComb,
    biasAComb, pulseLevel};
  wire [SEL_W-1:0] pinSel [NUM_PINS];
  wire [NUM_PINS-1:0] nxt_pin;
  logic [NUM_PINS-1:0] pin_ff;
  assign pinSel[0] = biasPinSourceSelect;
  assign pinSel[1] = mechShutterPinSourceSelect;
  assign pinSel[2] = flashPinSourceSelect;

  generate
    for (g = 0; g < NUM_PINS; g++) begin : gen_pin
      assign nxt_pin[g] = pinSource[pinSel[g]];
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!rst_n) pin_ff <= {NUM_PINS{PIN_IDLE_LEVEL}};
    else pin_ff <= nxt_pin;
  end

  assign substrateBias = pin_ff[0];
  assign mechShutterPin = pin_ff[1];
  assign flashPin = pin_ff[2];
  assign gatePulseState = pulseActive;
  assign biasState = biasActive;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence armedMode0;
    biasState_ff[0] == BIAS_ARMED && !biasMode[0];
  endsequence
  sequence field0LineHit;
    exposureField0 && lineCount == biasAOnLine && pixelCount == BIAS_ON_PIXEL;
  endsequence

  chk_bias_mode0_on: assert property (
    armedMode0 and field0LineHit |=> biasActive[0])
    else $error("bias a missed mode 0 turn-on");
  chk_bias_mode0_early: assert property (
    armedMode0 ##0 !(exposureField0 && lineCount == biasAOnLine &&
    pixelCount == BIAS_ON_PIXEL) |=> !biasActive[0])
    else $error("bias a turned on before its line");
  chk_bias_readout_off: assert property (
    biasState_ff[0] == BIAS_ON && readoutEnd && !biasHoldAfterReadout[0]
    |=> !biasActive[0])
    else $error("bias a not released at readout end");
  chk_bias_mode1_on: assert property (
    biasState_ff[1] == BIAS_ARMED && biasMode[1] && readoutStart
    |=> biasActive[1])
    else $error("bias b missed readout start");
  chk_bias_hold: assert property (
    biasActive[1] && readoutEnd && biasHoldAfterReadout[1]
    |=> biasActive[1])
    else $error("bias b dropped despite hold");
  chk_pulse_single: assert property (
    trigWrite && trigBits[TRIG_PULSE0] && !trigBits[TRIG_EXPOSURE]
    |=> pulseMode[0] == PULSE_SINGLE_WAIT)
    else $error("pulse 0 single trigger not armed");
  chk_pulse_auto: assert property (
    trigWrite && trigBits[TRIG_PULSE0+1] && trigBits[TRIG_EXPOSURE]
    |=> pulseMode[1] == PULSE_AUTO)
    else $error("pulse 1 not automatic with exposure");
  chk_pin_invalid: assert property (
    biasPinSourceSelect == SEL_INVALID |=> substrateBias == PIN_IDLE_LEVEL)
    else $error("invalid selector drove bias pin");
  chk_pin_route: assert property (
    flashPinSourceSelect == SEL_BIAS_A_COMB |=> flashPin == $past(biasAComb))
    else $error("flash pin not following bias a combiner");
  chk_pin_pulse12: assert property (
    mechShutterPinSourceSelect == SEL_PULSE12_COMB && !pulse12CombinerSel
    |=> mechShutterPin == $past(pulseLevel[0] ^ pulseLevel[1]))
    else $error("mech pin pulse12 combiner wrong");

endmodule // ccd_shutter_bias_control

// ===== field_timing_model.sv
`timescale 1ns/1ps
module field_timing_model
  import shutter_pkg::*;
#(
  parameter int PIX = 8,
  parameter int LINES = 4
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic expRun,
  output logic vdEdge,
  output logic [LINE_W-1:0] lineCount,
  output logic [PIXEL_W-1:0] pixelCount,
  output logic [FIELD_W-1:0] exposureCount,
  output logic exposureActive
);
  // ------------------------------------------------------------
  // Short fields keep the run brief
  // ------------------------------------------------------------
  logic lastPix;
  logic lastLine;
  assign lastPix = (pixelCount == PIXEL_W'(PIX - 1));
  assign lastLine = (lineCount == LINE_W'(LINES - 1));
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pixelCount <= '0;
      lineCount <= '0;
      vdEdge <= 1'b0;
      exposureActive <= 1'b0;
      exposureCount <= '0;
    end else begin
      pixelCount <= lastPix ? '0 : pixelCount + 1'b1;
      if (lastPix) begin
        lineCount <= lastLine ? '0 : lineCount + 1'b1;
      end
      vdEdge <= lastPix && lastLine;
      exposureActive <= expRun;
      if (!expRun) begin
        exposureCount <= '0;
      end else if (lastPix && lastLine && exposureActive) begin
        exposureCount <= exposureCount + 1'b1;
      end
    end
  end
endmodule // field_timing_model

// ===== ccd_shutter_bias_control_tb_top.sv
`timescale 1ns/1ps
module ccd_shutter_bias_control_tb_top import shutter_pkg::*;;
  logic clk = 1'b0, rst_n = 1'b0, expRun = 1'b0, trigWrite = 1'b0;
  logic readoutStart = 1'b0, readoutEnd = 1'b0;
  logic combA = 1'b0, combB = 1'b0, comb12 = 1'b0;
  logic vdEdge, exposureActive, substrateBias, mechShutterPin, flashPin;
  logic [7:0] trigBits = 8'h00;
  logic [1:0] biasMode = 2'h0, biasHold = 2'h0, biasPol = 2'h3;
  logic [1:0] biasState;
  logic [3:0] pulsePol = 4'hf, manEn = 4'h0, manOn = 4'h0;
  logic [3:0] gatePulseState;
  logic [LINE_W-1:0] lineCount, onLineA = 12'h002, onLineB = 12'h001;
  logic [PIXEL_W-1:0] pixelCount;
  logic [FIELD_W-1:0] exposureCount;
  logic [NUM_PULSES*FIELD_W-1:0] onFd = {12'h0, 12'h5, 12'h1, 12'h0};
  logic [NUM_PULSES*FIELD_W-1:0] offFd = {12'h0, 12'h5, 12'h2, 12'h0};
  logic [NUM_PULSES*LINE_W-1:0] onLn = {12'h0, 12'h1, 12'h1, 12'h0};
  logic [NUM_PULSES*LINE_W-1:0] offLn = {12'h0, 12'h3, 12'h2, 12'h0};
  logic [NUM_PULSES*PIXEL_W-1:0] onPx = {13'h0, 13'h4, 13'h2, 13'h0};
  logic [NUM_PULSES*PIXEL_W-1:0] offPx = {13'h0, 13'h1, 13'h3, 13'h0};
  logic [SEL_W-1:0] selBias = 3'h4, selMech = 3'h1, selFlash = 3'h6;
  int n_mismatch = 0;
  int checks = 0;

  always #5 clk = ~clk;

  field_timing_model tmg (.clk(clk), .rst_n(rst_n), .expRun(expRun),
    .vdEdge(vdEdge), .lineCount(lineCount), .pixelCount(pixelCount),
    .exposureCount(exposureCount), .exposureActive(exposureActive));

  ccd_shutter_bias_control uut (.clk(clk), .rst_n(rst_n), .vdEdge(vdEdge),
    .lineCount(lineCount), .pixelCount(pixelCount),
    .exposureCount(exposureCount), .exposureActive(exposureActive),
    .readoutStart(readoutStart), .readoutEnd(readoutEnd),
    .trigWrite(trigWrite), .trigBits(trigBits), .biasMode(biasMode),
    .biasHoldAfterReadout(biasHold), .biasPolarity(biasPol),
    .biasAOnLine(onLineA), .biasBOnLine(onLineB), .pulsePolarity(pulsePol),
    .pulseManualEnable(manEn), .pulseManualOn(manOn),
    .pulseOnField(onFd), .pulseOnLine(onLn), .pulseOnPixel(onPx),
    .pulseOffField(offFd), .pulseOffLine(offLn), .pulseOffPixel(offPx),
    .biasACombinerSel(combA), .biasBCombinerSel(combB),
    .pulse12CombinerSel(comb12), .biasPinSourceSelect(selBias),
    .mechShutterPinSourceSelect(selMech), .flashPinSourceSelect(selFlash),
    .substrateBias(substrateBias), .mechShutterPin(mechShutterPin),
    .flashPin(flashPin), .gatePulseState(gatePulseState),
    .biasState(biasState));

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic step(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wait_pos(input int l, input int p);
    int n;
    n = 0;
    do begin
      step();
      n++;
    end while (!(lineCount == LINE_W'(l) && pixelCount == PIXEL_W'(p))
               && n < 64);
    if (!(lineCount == LINE_W'(l) && pixelCount == PIXEL_W'(p))) begin
      n_mismatch++;
      $display("MISMATCH wait_pos expected reached seen timeout");
    end
  endtask

  task automatic chk(input string name, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic trig(input logic [7:0] bits);
    trigBits = bits;
    trigWrite = 1'b1;
    step();
    trigWrite = 1'b0;
  endtask

  task automatic strobe(ref logic sig);
    sig = 1'b1;
    step();
    sig = 1'b0;
  endtask

  function automatic logic route(input int s, input logic [3:0] p,
                                 input logic [1:0] b, input logic c);
    case (s)
      4: return c ? p[0] ^ b[0] : b[0];
      5: return c ? p[0] ^ b[1] : b[1];
      6: return 1'b0;
      7: return c ? p[0] ^ p[2] : p[0] ^ p[1];
      default: return p[s];
    endcase
  endfunction

  task automatic conclude();
    $display("Counts: checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    #100000;
    n_mismatch++;
    conclude();
  end

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    step(2);
    rst_n = 1'b1;
    wait_pos(0, 0);
    expRun = 1'b1;
    step(2);
    trig(8'h52);
    wait_pos(1, 2);
    step();
    chk("pulse1 field0", 1'b0, gatePulseState[1]);
    chk("biasA early", 1'b0, biasState[0]);
    wait_pos(2, 0);
    step();
    chk("biasA on", 1'b1, biasState[0]);
    step();
    chk("bias pin A", 1'b1, substrateBias);
    combA = 1'b1;
    pulsePol = 4'he;
    step();
    chk("bias A xor", 1'b0, substrateBias);
    combA = 1'b0;
    pulsePol = 4'hf;
    wait_pos(1, 2);
    step();
    chk("pulse1 on", 1'b1, gatePulseState[1]);
    step();
    chk("mech pin", 1'b1, mechShutterPin);
    wait_pos(2, 3);
    step();
    chk("pulse1 field1", 1'b1, gatePulseState[1]);
    wait_pos(2, 3);
    step();
    chk("pulse1 off", 1'b0, gatePulseState[1]);
    expRun = 1'b0;
    strobe(readoutStart);
    chk("biasA kept", 1'b1, biasState[0]);
    strobe(readoutEnd);
    chk("biasA off", 1'b0, biasState[0]);
    $display("Test auto done");
    biasMode = 2'h2;
    biasHold = 2'h2;
    biasPol = 2'h1;
    selBias = 3'h5;
    trig(8'h20);
    step(3);
    chk("biasB waits", 1'b0, biasState[1]);
    chk("biasB idle pin", 1'b1, substrateBias);
    strobe(readoutStart);
    chk("biasB on", 1'b1, biasState[1]);
    step();
    chk("biasB pin", 1'b0, substrateBias);
    strobe(readoutEnd);
    step(3);
    chk("biasB held", 1'b1, biasState[1]);
    biasHold = 2'h0;
    step();
    chk("biasB released", 1'b0, biasState[1]);
    biasPol = 2'h3;
    $display("Test bias mode 1 done");
    manEn = 4'h4;
    manOn = 4'h4;
    wait_pos(1, 4);
    step();
    chk("manual on", 1'b1, gatePulseState[2]);
    for (int s = 0; s < 8; s++) begin
      for (int c = 0; c < 2; c++) begin
        selBias = SEL_W'(s);
        selMech = SEL_W'(s);
        selFlash = SEL_W'(s);
        combA = c[0];
        combB = c[0];
        comb12 = c[0];
        step();
        chk("bias pin", route(s, 4'h4, 2'h0, c[0]), substrateBias);
        chk("mech pin", route(s, 4'h4, 2'h0, c[0]), mechShutterPin);
        chk("flash pin", route(s, 4'h4, 2'h0, c[0]), flashPin);
      end
    end
    $display("Test routing done");
    manEn = 4'h0;
    step();
    chk("left on", 1'b1, gatePulseState[2]);
    trig(8'h05);
    wait_pos(0, 0);
    wait_pos(1, 4);
    step();
    chk("on ignored", 1'b1, gatePulseState[2]);
    wait_pos(3, 1);
    step();
    chk("single off", 1'b0, gatePulseState[2]);
    $display("Test manual done");
    conclude();
  end
endmodule // ccd_shutter_bias_control_tb_top
